//--- verilog/srg_pkg.sv
// Shared constants, commands and carriers of the status reporting block
`default_nettype none
package srg_pkg;
	// Width of each status group register and of command data
	localparam int GRP_W = 15;
	localparam int DATA_W = 16;
	// Filter, enable and event reset and preset values
	localparam logic [14:0] RISE_RST = 15'h7FFF;
	localparam logic [14:0] FALL_RST = 15'h0000;
	localparam logic [14:0] ENA_RST = 15'h0000;
	localparam logic [14:0] EVT_RST = 15'h0000;
	// Operation group bit positions
	localparam int OP_CAL_BIT = 0;
	localparam int OP_WAIT_BIT = 5;
	localparam int OP_CV_BIT = 8;
	localparam int OP_CV2_BIT = 9;
	localparam int OP_CCP_BIT = 10;
	localparam int OP_CCN_BIT = 11;
	localparam int OP_CC2_BIT = 12;
	// Warning group bit positions
	localparam int WN_OV_BIT = 0;
	localparam int WN_OCP_BIT = 1;
	localparam int WN_FP_BIT = 3;
	localparam int WN_OT_BIT = 4;
	localparam int WN_SD_BIT = 5;
	localparam int WN_AUX_OUT_NOT_REGULATED_BIT = 8;
	localparam int WN_RI_BIT = 9;
	localparam int WN_UNR_BIT = 10;
	localparam int WN_OC2_BIT = 12;
	localparam int WN_OVLD_BIT = 14;
	// Summary bit positions in the status byte
	localparam int SB_WARN_BIT = 3;
	localparam int SB_OP_BIT = 7;
	// Voltages in millivolts: ceiling reset 22 V, guard margin 2 V
	localparam logic [15:0] CEIL_RST_MV = 16'h55F0;
	localparam logic [15:0] GUARD_MARGIN_MV = 16'h07D0;
	localparam logic [15:0] VOLT_RST_MV = 16'h0000;
	localparam logic [15:0] PEND_RST_MV = 16'h0000;
	// Commands of the remote command port
	typedef enum logic [4:0] {
		SRG_OP_COND_RD, SRG_OP_EVT_RD, SRG_OP_ENA_WR, SRG_OP_ENA_RD,
		SRG_OP_FALL_WR, SRG_OP_FALL_RD, SRG_OP_RISE_WR, SRG_OP_RISE_RD,
		SRG_WN_COND_RD, SRG_WN_EVT_RD, SRG_WN_ENA_WR, SRG_WN_ENA_RD,
		SRG_WN_FALL_WR, SRG_WN_FALL_RD, SRG_WN_RISE_WR, SRG_WN_RISE_RD,
		SRG_PRESET, SRG_VOLT_WR, SRG_VOLT_RD, SRG_CEIL_WR, SRG_CEIL_RD,
		SRG_GUARD_WR, SRG_GUARD_RD, SRG_PEND_WR, SRG_PEND_RD
	} srg_cmd_e;
	// Raw operation state lines
	typedef struct packed {
		logic calib_computing;
		logic main_const_volt;
		logic aux_const_volt;
		logic const_current_positive;
		logic const_current_negative;
		logic aux_const_current;
	} srg_op_s;
	// Raw warning state lines
	typedef struct packed {
		logic main_high_volt_trip;
		logic main_overcurrent_trip;
		logic front_panel_local_key;
		logic temp_trip;
		logic sense_lead_open;
		logic aux_out_not_regulated;
		logic remote_inhibit_active;
		logic main_out_not_regulated;
		logic aux_overcurrent_trip;
		logic meas_overload;
	} srg_warn_s;
	// State of one status group
	typedef struct packed {
		logic [14:0] cond_q;
		logic [14:0] rise_q;
		logic [14:0] fall_q;
		logic [14:0] ena_q;
		logic [14:0] evt_q;
		logic sum_q;
	} srg_grp_s;
endpackage : srg_pkg
`default_nettype wire

//--- verilog/srg_group.sv
// One status group: transition filters, latched events, enable summary
`default_nettype none
module srg_group
	import srg_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Live condition, already in this clock domain
	input wire logic [14:0] cond,
	// Register access pulses
	input wire logic preset,
	input wire logic ena_wr,
	input wire logic fall_wr,
	input wire logic rise_wr,
	input wire logic [14:0] wr_data,
	input wire logic evt_rd,
	// Register contents
	output logic [14:0] rise_q,
	output logic [14:0] fall_q,
	output logic [14:0] ena_q,
	output logic [14:0] evt_q,
	output logic sum_q
);
	srg_grp_s q, d; // Whole group state and its next value
	logic [14:0] hit; // Filtered transitions this cycle

	// Edge filters, event latch and summary
	always_comb begin
		d = q;
		d.cond_q = cond;
		hit = (q.rise_q & cond & ~q.cond_q)
			| (q.fall_q & ~cond & q.cond_q);
		// Read clears, but a new hit in the same cycle survives
		if (evt_rd) begin
			d.evt_q = EVT_RST;
		end
		d.evt_q = d.evt_q | hit;
		if (ena_wr) begin
			d.ena_q = wr_data;
		end
		if (fall_wr) begin
			d.fall_q = wr_data;
		end
		if (rise_wr) begin
			d.rise_q = wr_data;
		end
		// Preset overrides a write in the same cycle
		if (preset) begin
			d.rise_q = RISE_RST;
			d.fall_q = FALL_RST;
			d.ena_q = ENA_RST;
		end
		d.sum_q = |(d.evt_q & d.ena_q);
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '{cond_q: 15'h0000, rise_q: RISE_RST, fall_q: FALL_RST,
				ena_q: ENA_RST, evt_q: EVT_RST, sum_q: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign rise_q = q.rise_q;
	assign fall_q = q.fall_q;
	assign ena_q = q.ena_q;
	assign evt_q = q.evt_q;
	assign sum_q = q.sum_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	evt_catch_a: assert property ((|hit) |=> ((evt_q & $past(hit)) == $past(hit)))
		else $error("filtered transition not latched");
	evt_clear_a: assert property ((evt_rd && hit == 15'h0000) |=> evt_q == 15'h0000)
		else $error("event register not cleared by read");
	preset_vals_a: assert property (preset |=> (rise_q == 15'h7FFF
		&& fall_q == 15'h0000 && ena_q == 15'h0000))
		else $error("preset values wrong");
	summary_or_a: assert property (sum_q == |(evt_q & ena_q))
		else $error("summary does not match enabled events");
endmodule : srg_group
`default_nettype wire

//--- verilog/srg_status_top.sv
// Status groups, voltage ceiling, tracking guard and pending voltage
// What this block does
// - Both groups: condition, enable, event, two filters
// - Preset sets rising filters, clears falling filters and enables
// - Preset values: falling 0, rising 32767
// - Falling filter bit catches one-to-zero change
// - Rising filter bit catches zero-to-one change
// - Operation events read-only, latched until read
// - Operation event read returns, then clears
// - Operation bit positions fixed
// - Operation condition is live, read-only
// - Status bit 7 ORs enabled operation events
// - Warning events latched, cleared on read
// - Warning bit positions fixed
// - Warning condition is live, read-only
// - Status bit 3 ORs enabled warning events
// - Enabled guard trips two volts above setting
// - Guard off keeps the voltage ceiling
// - No voltage above the ceiling is accepted; a lower ceiling leaves a higher setting in place
// - Pending voltage moves on initiated trigger
`default_nettype none
module srg_status_top
	import srg_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Remote command port
	input wire logic cmd_valid,
	input wire srg_cmd_e cmd_code,
	input wire logic [15:0] cmd_data,
	output logic resp_valid_q,
	output logic resp_err_q,
	output logic [15:0] resp_data_q,
	// Front panel voltage entry
	input wire logic panel_valid,
	input wire logic [15:0] panel_volt,
	output logic panel_reject_q,
	// Raw state lines from the output stage
	input wire srg_op_s op_pins,
	input wire srg_warn_s warn_pins,
	// Trigger system and measurement, same clock
	input wire logic trig_init,
	input wire logic trig_event,
	input wire logic [15:0] meas_volt,
	// Results
	output logic [7:0] status_byte,
	output logic [15:0] prog_volt_q,
	output logic guard_trip_q
);
	// Whole state of the top level
	typedef struct packed {
		logic [14:0] op_s1;
		logic [14:0] op_s2;
		logic [14:0] op_s3;
		logic [14:0] op_stab;
		logic [14:0] wn_s1;
		logic [14:0] wn_s2;
		logic [14:0] wn_s3;
		logic [14:0] wn_stab;
		logic trig_wait;
		logic [15:0] prog;
		logic [15:0] ceil;
		logic [15:0] pend;
		logic guard_en;
		logic guard_trip;
		logic resp_valid;
		logic resp_err;
		logic [15:0] resp_data;
		logic panel_reject;
	} srg_top_s;

	srg_top_s q, d; // State and next state
	logic [14:0] op_raw; // Operation lines at their bit positions
	logic [14:0] wn_raw; // Warning lines at their bit positions
	logic [14:0] op_cond; // Live operation condition
	logic [14:0] wn_cond; // Live warning condition
	logic [14:0] wdat; // Low bits of command data
	logic preset; // Preset pulse to both groups
	logic op_evt_rd; // Operation event read
	logic wn_evt_rd; // Warning event read
	logic [14:0] op_rise, op_fall, op_ena, op_evt; // Operation registers
	logic [14:0] wn_rise, wn_fall, wn_ena, wn_evt; // Warning registers
	logic op_sum, wn_sum; // Group summaries
	logic [16:0] guard_lim; // Setting plus margin, no overflow
	logic guard_over; // Measured output above the guard limit

	// Place raw lines at their documented bit positions
	always_comb begin
		// Operation lines; trigger wait is filled in later
		op_raw = 15'h0000;
		op_raw[OP_CAL_BIT] = op_pins.calib_computing;
		op_raw[OP_CV_BIT] = op_pins.main_const_volt;
		op_raw[OP_CV2_BIT] = op_pins.aux_const_volt;
		op_raw[OP_CCP_BIT] = op_pins.const_current_positive;
		op_raw[OP_CCN_BIT] = op_pins.const_current_negative;
		op_raw[OP_CC2_BIT] = op_pins.aux_const_current;
		// Warning lines; unused positions stay low
		wn_raw = 15'h0000;
		wn_raw[WN_OV_BIT] = warn_pins.main_high_volt_trip;
		wn_raw[WN_OCP_BIT] = warn_pins.main_overcurrent_trip;
		wn_raw[WN_FP_BIT] = warn_pins.front_panel_local_key;
		wn_raw[WN_OT_BIT] = warn_pins.temp_trip;
		wn_raw[WN_SD_BIT] = warn_pins.sense_lead_open;
		wn_raw[WN_AUX_OUT_NOT_REGULATED_BIT] = warn_pins.aux_out_not_regulated;
		wn_raw[WN_RI_BIT] = warn_pins.remote_inhibit_active;
		wn_raw[WN_UNR_BIT] = warn_pins.main_out_not_regulated;
		wn_raw[WN_OC2_BIT] = warn_pins.aux_overcurrent_trip;
		wn_raw[WN_OVLD_BIT] = warn_pins.meas_overload;
	end

	// Live conditions: filtered lines plus internal state
	always_comb begin
		op_cond = q.op_stab;
		op_cond[OP_WAIT_BIT] = q.trig_wait;
		// A guard trip also shows as the main voltage trip
		wn_cond = q.wn_stab;
		wn_cond[WN_OV_BIT] = q.wn_stab[WN_OV_BIT] | q.guard_trip;
	end

	// Command decode into group strobes
	assign wdat = cmd_data[14:0];
	assign preset = cmd_valid && cmd_code == SRG_PRESET;
	assign op_evt_rd = cmd_valid && cmd_code == SRG_OP_EVT_RD;
	assign wn_evt_rd = cmd_valid && cmd_code == SRG_WN_EVT_RD;
	// Limit is one bit wider so a high setting cannot wrap
	assign guard_lim = {1'b0, q.prog} + {1'b0, GUARD_MARGIN_MV};
	assign guard_over = {1'b0, meas_volt} > guard_lim;

	// Operation group
	srg_group u_op_group (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.cond(op_cond),
		.preset(preset),
		.ena_wr(cmd_valid && cmd_code == SRG_OP_ENA_WR),
		.fall_wr(cmd_valid && cmd_code == SRG_OP_FALL_WR),
		.rise_wr(cmd_valid && cmd_code == SRG_OP_RISE_WR),
		.wr_data(wdat),
		.evt_rd(op_evt_rd),
		.rise_q(op_rise),
		.fall_q(op_fall),
		.ena_q(op_ena),
		.evt_q(op_evt),
		.sum_q(op_sum)
	);

	// Warning group
	srg_group u_wn_group (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.cond(wn_cond),
		.preset(preset),
		.ena_wr(cmd_valid && cmd_code == SRG_WN_ENA_WR),
		.fall_wr(cmd_valid && cmd_code == SRG_WN_FALL_WR),
		.rise_wr(cmd_valid && cmd_code == SRG_WN_RISE_WR),
		.wr_data(wdat),
		.evt_rd(wn_evt_rd),
		.rise_q(wn_rise),
		.fall_q(wn_fall),
		.ena_q(wn_ena),
		.evt_q(wn_evt),
		.sum_q(wn_sum)
	);

	// Next state: synchronisers, voltage settings, guard, answers
	always_comb begin
		d = q;
		// Three stages; a change counts once stages two and three agree
		d.op_s1 = op_raw;
		d.op_s2 = q.op_s1;
		d.op_s3 = q.op_s2;
		d.op_stab = (q.op_s2 & q.op_s3) | (q.op_stab & (q.op_s2 ^ q.op_s3));
		d.wn_s1 = wn_raw;
		d.wn_s2 = q.wn_s1;
		d.wn_s3 = q.wn_s2;
		d.wn_stab = (q.wn_s2 & q.wn_s3) | (q.wn_stab & (q.wn_s2 ^ q.wn_s3));
		// Trigger wait shows the initiated state one cycle later
		d.trig_wait = trig_init;
		// Every command is answered once; answers default to plain success
		d.resp_valid = cmd_valid;
		d.resp_err = 1'b0;
		d.resp_data = 16'h0000;
		d.panel_reject = 1'b0;
		// Front panel entry, refused above the ceiling
		// A remote voltage write in the same cycle wins over the panel
		if (panel_valid && !(cmd_valid && cmd_code == SRG_VOLT_WR)) begin
			if (panel_volt > q.ceil) begin
				d.panel_reject = 1'b1;
			end else begin
				d.prog = panel_volt;
			end
		end
		// Remote commands; reads return the value before any clear
		if (cmd_valid) begin
			unique case (cmd_code)
				SRG_OP_COND_RD: d.resp_data = {1'b0, op_cond};
				SRG_OP_EVT_RD: d.resp_data = {1'b0, op_evt};
				SRG_OP_ENA_RD: d.resp_data = {1'b0, op_ena};
				SRG_OP_FALL_RD: d.resp_data = {1'b0, op_fall};
				SRG_OP_RISE_RD: d.resp_data = {1'b0, op_rise};
				SRG_WN_COND_RD: d.resp_data = {1'b0, wn_cond};
				SRG_WN_EVT_RD: d.resp_data = {1'b0, wn_evt};
				SRG_WN_ENA_RD: d.resp_data = {1'b0, wn_ena};
				SRG_WN_FALL_RD: d.resp_data = {1'b0, wn_fall};
				SRG_WN_RISE_RD: d.resp_data = {1'b0, wn_rise};
				SRG_OP_ENA_WR, SRG_OP_FALL_WR, SRG_OP_RISE_WR,
				SRG_WN_ENA_WR, SRG_WN_FALL_WR, SRG_WN_RISE_WR,
				SRG_PRESET: d.resp_data = 16'h0000;
				// Settings above the ceiling are refused with an error
				SRG_VOLT_WR: begin
					if (cmd_data > q.ceil) begin
						d.resp_err = 1'b1;
					end else begin
						d.prog = cmd_data;
					end
				end
				SRG_VOLT_RD: d.resp_data = q.prog;
				// A lower ceiling leaves a higher setting in place
				SRG_CEIL_WR: d.ceil = cmd_data;
				SRG_CEIL_RD: d.resp_data = q.ceil;
				SRG_GUARD_WR: begin
					// Guard only; the ceiling is untouched
					d.guard_en = cmd_data[0];
					d.guard_trip = 1'b0;
				end
				SRG_GUARD_RD: d.resp_data = {15'h0000, q.guard_en};
				SRG_PEND_WR: begin
					if (cmd_data > q.ceil) begin
						d.resp_err = 1'b1;
					end else begin
						d.pend = cmd_data;
					end
				end
				SRG_PEND_RD: d.resp_data = q.pend;
				// Codes outside the command set are refused
				default: d.resp_err = 1'b1;
			endcase
		end
		// Trigger while initiated moves the pending level, if allowed
		if (trig_event && trig_init && q.pend <= q.ceil) begin
			d.prog = q.pend;
		end
		// Tracking guard: a trip is sticky and wins over the clear
		if (q.guard_en && guard_over) begin
			d.guard_trip = 1'b1;
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			// Settings at their defaults, guard off, ceiling at 22 V
			q <= '{op_s1: 15'h0000, op_s2: 15'h0000, op_s3: 15'h0000,
				op_stab: 15'h0000, wn_s1: 15'h0000, wn_s2: 15'h0000,
				wn_s3: 15'h0000, wn_stab: 15'h0000, trig_wait: 1'b0,
				prog: VOLT_RST_MV, ceil: CEIL_RST_MV, pend: PEND_RST_MV,
				guard_en: 1'b0, guard_trip: 1'b0, resp_valid: 1'b0,
				resp_err: 1'b0, resp_data: 16'h0000, panel_reject: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Outputs straight from state
	assign resp_valid_q = q.resp_valid;
	assign resp_err_q = q.resp_err;
	assign resp_data_q = q.resp_data;
	assign panel_reject_q = q.panel_reject;
	assign prog_volt_q = q.prog;
	assign guard_trip_q = q.guard_trip;
	// Summary bits come from group flip-flops
	always_comb begin
		status_byte = 8'h00;
		status_byte[SB_OP_BIT] = op_sum;
		status_byte[SB_WARN_BIT] = wn_sum;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// Checks on the settings, the guard, the answers and the summaries
	// A remote setting above the ceiling is answered with an error, not applied
	volt_refuse_a: assert property ((cmd_valid && cmd_code == SRG_VOLT_WR
		&& cmd_data > q.ceil && !(trig_event && trig_init))
		|=> (resp_err_q && $stable(prog_volt_q)))
		else $error("voltage above ceiling accepted");
	// A panel entry above the ceiling raises the reject flag, not applied
	panel_refuse_a: assert property ((panel_valid && panel_volt > q.ceil
		&& !(cmd_valid && cmd_code == SRG_VOLT_WR) && !(trig_event && trig_init))
		|=> (panel_reject_q && $stable(prog_volt_q)))
		else $error("panel voltage above ceiling accepted");
	// A pending level above the ceiling is refused and the stored level kept
	pend_refuse_a: assert property ((cmd_valid && cmd_code == SRG_PEND_WR
		&& cmd_data > q.ceil) |=> (resp_err_q && $stable(q.pend)))
		else $error("pending level above ceiling accepted");
	// Only a ceiling write moves the ceiling; the guard switch never does
	ceil_keep_a: assert property (!(cmd_valid && cmd_code == SRG_CEIL_WR)
		|=> $stable(q.ceil))
		else $error("ceiling moved without a ceiling write");
	// The guard trips one cycle after the output passes the limit
	guard_trip_a: assert property ((q.guard_en && guard_over) |=> guard_trip_q)
		else $error("guard did not trip");
	// A guard that is off and clear stays clear
	guard_off_a: assert property ((!q.guard_en && !guard_trip_q) |=> !guard_trip_q)
		else $error("guard tripped while off");
	// A guard write clears a trip unless a new one arrives at once
	guard_clear_a: assert property ((cmd_valid && cmd_code == SRG_GUARD_WR
		&& !(q.guard_en && guard_over)) |=> !guard_trip_q)
		else $error("guard write did not clear the trip");
	// A trigger while initiated applies the pending level
	trig_move_a: assert property ((trig_event && trig_init && q.pend <= q.ceil)
		|=> prog_volt_q == $past(q.pend))
		else $error("pending level not applied");
	// A trigger while not initiated is ignored
	trig_hold_a: assert property ((trig_event && !trig_init
		&& !cmd_valid && !panel_valid) |=> $stable(prog_volt_q))
		else $error("trigger applied while not initiated");
	// Condition reads return the live operation state
	cond_read_a: assert property ((cmd_valid && cmd_code == SRG_OP_COND_RD)
		|=> (resp_valid_q && resp_data_q == {1'b0, $past(op_cond)}))
		else $error("condition read wrong");
	// An event read answers with the value held before the clear
	evt_read_a: assert property (op_evt_rd
		|=> resp_data_q == {1'b0, $past(op_evt)})
		else $error("event read lost old value");
	// Warning event reads answer the same way
	wn_evt_read_a: assert property (wn_evt_rd
		|=> (resp_valid_q && resp_data_q == {1'b0, $past(wn_evt)}))
		else $error("warning event read wrong");
	// Summary bits sit at their places in the status byte
	op_sum_a: assert property (status_byte[SB_OP_BIT] == |(op_evt & op_ena))
		else $error("operation summary bit wrong");
	wn_sum_a: assert property (status_byte[SB_WARN_BIT] == |(wn_evt & wn_ena))
		else $error("warning summary bit wrong");
	// Status byte bits other than the two summaries stay low
	spare_bits_a: assert property ((status_byte & 8'h77) == 8'h00)
		else $error("unused status byte bit set");
	// Stages two and three agreeing move the filtered condition
	stab_agree_a: assert property ((q.op_s2 == q.op_s3)
		|=> q.op_stab == $past(q.op_s2))
		else $error("agreeing stages not taken");
	// Disagreeing stages leave the filtered condition alone
	stab_hold_a: assert property ((q.wn_s2 != q.wn_s3) |=> $stable(q.wn_stab))
		else $error("disagreeing stages changed the condition");
endmodule : srg_status_top
`default_nettype wire

//--- verification/tb_srg_status_top.sv
// Self-checking bench for the status reporting block
`default_nettype none
module tb_srg_status_top import srg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// Clock, reset and stimulus
	logic ref_clk, reset_n, cmd_valid, panel_valid, trig_init, trig_event;
	srg_cmd_e cmd_code;
	logic [15:0] cmd_data, panel_volt, meas_volt;
	srg_op_s op_pins;
	srg_warn_s warn_pins;
	// Observed outputs
	logic resp_valid_q, resp_err_q, panel_reject_q, guard_trip_q;
	logic [15:0] resp_data_q, prog_volt_q;
	logic [7:0] status_byte;
	// Bookkeeping
	int n_errors, tests_run, cycles;
	// Bit positions in struct order, most significant field first
	int op_pos[6] = '{0, 8, 9, 10, 11, 12};
	int wn_pos[10] = '{0, 1, 3, 4, 5, 8, 9, 10, 12, 14};
	// Filter settings and expected rising and falling captures
	logic [15:0] fl[3] = '{16'h0100, 16'h0100, 16'h0000};
	logic [15:0] rs[3] = '{16'h0000, 16'h0100, 16'h0000};

	srg_status_top uut (
		.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_data(cmd_data), .resp_valid_q(resp_valid_q), .resp_err_q(resp_err_q),
		.resp_data_q(resp_data_q), .panel_valid(panel_valid), .panel_volt(panel_volt),
		.panel_reject_q(panel_reject_q), .op_pins(op_pins), .warn_pins(warn_pins),
		.trig_init(trig_init), .trig_event(trig_event), .meas_volt(meas_volt),
		.status_byte(status_byte), .prog_volt_q(prog_volt_q), .guard_trip_q(guard_trip_q)
	);

	// Free-running system clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Compare one value, count it, report a mismatch
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Let n falling edges pass
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// One command; the answer stands for one cycle after the taking edge
	// A free cycle follows, so the strobe is never lowered and raised at once
	task automatic cmd(input srg_cmd_e code, input logic [15:0] data, input logic [15:0] exp,
		input logic err);
		cmd_code = code;
		cmd_data = data;
		cmd_valid = 1'b1;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		check("resp_valid", {15'h0, resp_valid_q}, 16'h0001);
		check("resp_err", {15'h0, resp_err_q}, {15'h0, err});
		check("resp_data", resp_data_q, exp);
		@(negedge ref_clk);
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Cut a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			wrap_up();
		end
	end

	// Main sequence
	initial begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = SRG_OP_COND_RD;
		cmd_data = 16'h0000;
		panel_valid = 1'b0;
		panel_volt = 16'h0000;
		op_pins = '0;
		warn_pins = '0;
		trig_init = 1'b0;
		trig_event = 1'b0;
		meas_volt = 16'h0000;
		idle(5);
		reset_n = 1'b1;
		// Reset values of the register set
		cmd(SRG_OP_RISE_RD, 16'h0, 16'h7FFF, 1'b0);
		cmd(SRG_WN_RISE_RD, 16'h0, 16'h7FFF, 1'b0);
		cmd(SRG_OP_FALL_RD, 16'h0, 16'h0000, 1'b0);
		cmd(SRG_WN_ENA_RD, 16'h0, 16'h0000, 1'b0);
		cmd(SRG_CEIL_RD, 16'h0, 16'h55F0, 1'b0);
		cmd(SRG_PEND_RD, 16'h0, 16'h0000, 1'b0);
		cmd(SRG_GUARD_RD, 16'h0, 16'h0000, 1'b0);
		check("status_byte", {8'h0, status_byte}, 16'h0000);
		$display("reset values done");
		// Each operation line lands on its bit, latches, clears on read
		for (int i = 0; i < 6; i++) begin
			op_pins = srg_op_s'(6'h20 >> i);
			idle(8);
			cmd(SRG_OP_COND_RD, 16'h0, 16'h1 << op_pos[i], 1'b0);
			cmd(SRG_OP_EVT_RD, 16'h0, 16'h1 << op_pos[i], 1'b0);
			cmd(SRG_OP_EVT_RD, 16'h0, 16'h0000, 1'b0);
			op_pins = '0;
			idle(8);
			cmd(SRG_OP_EVT_RD, 16'h0, 16'h0000, 1'b0);
		end
		trig_init = 1'b1;
		idle(8);
		cmd(SRG_OP_COND_RD, 16'h0, 16'h0020, 1'b0);
		cmd(SRG_OP_EVT_RD, 16'h0, 16'h0020, 1'b0);
		trig_init = 1'b0;
		idle(8);
		$display("operation bits done");
		// Each warning line lands on its bit, latches, clears on read
		for (int i = 0; i < 10; i++) begin
			warn_pins = srg_warn_s'(10'h200 >> i);
			idle(8);
			cmd(SRG_WN_COND_RD, 16'h0, 16'h1 << wn_pos[i], 1'b0);
			cmd(SRG_WN_EVT_RD, 16'h0, 16'h1 << wn_pos[i], 1'b0);
			cmd(SRG_WN_EVT_RD, 16'h0, 16'h0000, 1'b0);
			warn_pins = '0;
			idle(8);
			cmd(SRG_WN_COND_RD, 16'h0, 16'h0000, 1'b0);
		end
		cmd(SRG_OP_EVT_RD, 16'h0, 16'h0000, 1'b0);
		$display("warning bits done");
		// Falling only, both, neither on the constant voltage bit
		for (int i = 0; i < 3; i++) begin
			cmd(SRG_OP_FALL_WR, fl[i], 16'h0000, 1'b0);
			cmd(SRG_OP_RISE_WR, rs[i], 16'h0000, 1'b0);
			cmd(SRG_OP_FALL_RD, 16'h0, fl[i], 1'b0);
			op_pins = srg_op_s'(6'h10);
			idle(8);
			cmd(SRG_OP_EVT_RD, 16'h0, rs[i], 1'b0);
			op_pins = '0;
			idle(8);
			cmd(SRG_OP_EVT_RD, 16'h0, fl[i], 1'b0);
		end
		$display("filters done");
		// Preset restores filters and masks; bit 15 is dropped
		cmd(SRG_WN_FALL_WR, 16'h0010, 16'h0000, 1'b0);
		cmd(SRG_WN_RISE_WR, 16'h0200, 16'h0000, 1'b0);
		cmd(SRG_WN_ENA_WR, 16'h1000, 16'h0000, 1'b0);
		cmd(SRG_OP_ENA_WR, 16'hFFFF, 16'h0000, 1'b0);
		cmd(SRG_OP_ENA_RD, 16'h0, 16'h7FFF, 1'b0);
		cmd(SRG_PRESET, 16'h0, 16'h0000, 1'b0);
		cmd(SRG_WN_RISE_RD, 16'h0, 16'h7FFF, 1'b0);
		cmd(SRG_WN_FALL_RD, 16'h0, 16'h0000, 1'b0);
		cmd(SRG_WN_ENA_RD, 16'h0, 16'h0000, 1'b0);
		cmd(SRG_OP_ENA_RD, 16'h0, 16'h0000, 1'b0);
		cmd(SRG_OP_RISE_RD, 16'h0, 16'h7FFF, 1'b0);
		$display("preset done");
		// Summary bits follow enabled events and drop on read
		cmd(SRG_OP_ENA_WR, 16'h0100, 16'h0000, 1'b0);
		cmd(SRG_WN_ENA_WR, 16'h1000, 16'h0000, 1'b0);
		op_pins = srg_op_s'(6'h10);
		warn_pins = srg_warn_s'(10'h002);
		idle(8);
		check("status_byte", {8'h0, status_byte}, 16'h0088);
		cmd(SRG_OP_EVT_RD, 16'h0, 16'h0100, 1'b0);
		check("status_byte", {8'h0, status_byte}, 16'h0008);
		cmd(SRG_WN_EVT_RD, 16'h0, 16'h1000, 1'b0);
		check("status_byte", {8'h0, status_byte}, 16'h0000);
		op_pins = '0;
		warn_pins = '0;
		idle(8);
		$display("summary done");
		// A read in the cycle that latches a new bit answers the old value
		trig_init = 1'b1;
		idle(1);
		cmd(SRG_OP_EVT_RD, 16'h0, 16'h0000, 1'b0);
		cmd(SRG_OP_EVT_RD, 16'h0, 16'h0020, 1'b0);
		trig_init = 1'b0;
		$display("same cycle read done");
		// Ceiling refuses remote and panel settings above it
		cmd(SRG_CEIL_WR, 16'h2710, 16'h0000, 1'b0);
		cmd(SRG_VOLT_WR, 16'h2711, 16'h0000, 1'b1);
		cmd(SRG_VOLT_RD, 16'h0, 16'h0000, 1'b0);
		cmd(SRG_VOLT_WR, 16'h2710, 16'h0000, 1'b0);
		check("prog_volt", prog_volt_q, 16'h2710);
		panel_volt = 16'h2800;
		panel_valid = 1'b1;
		idle(1);
		panel_valid = 1'b0;
		check("panel_reject", {15'h0, panel_reject_q}, 16'h0001);
		check("prog_volt", prog_volt_q, 16'h2710);
		idle(1);
		panel_volt = 16'h1000;
		panel_valid = 1'b1;
		idle(1);
		panel_valid = 1'b0;
		check("prog_volt", prog_volt_q, 16'h1000);
		// Guard trips only strictly above setting plus two volts
		cmd(SRG_GUARD_WR, 16'h0001, 16'h0000, 1'b0);
		meas_volt = 16'h17D0;
		idle(2);
		check("guard_trip", {15'h0, guard_trip_q}, 16'h0000);
		meas_volt = 16'h17D1;
		idle(2);
		check("guard_trip", {15'h0, guard_trip_q}, 16'h0001);
		meas_volt = 16'h0000;
		cmd(SRG_GUARD_WR, 16'h0000, 16'h0000, 1'b0);
		check("guard_trip", {15'h0, guard_trip_q}, 16'h0000);
		cmd(SRG_VOLT_WR, 16'h2711, 16'h0000, 1'b1);
		$display("ceiling and guard done");
		// Pending level moves only on a trigger while initiated
		cmd(SRG_PEND_WR, 16'h2711, 16'h0000, 1'b1);
		cmd(SRG_PEND_WR, 16'h0800, 16'h0000, 1'b0);
		cmd(SRG_PEND_RD, 16'h0, 16'h0800, 1'b0);
		trig_event = 1'b1;
		idle(1);
		trig_event = 1'b0;
		idle(1);
		check("prog_volt", prog_volt_q, 16'h1000);
		trig_init = 1'b1;
		trig_event = 1'b1;
		idle(1);
		trig_event = 1'b0;
		trig_init = 1'b0;
		check("prog_volt", prog_volt_q, 16'h0800);
		// An unused command code is refused
		cmd(srg_cmd_e'(5'h1F), 16'h0, 16'h0000, 1'b1);
		$display("pending and refusal done");
		wrap_up();
	end
endmodule // tb_srg_status_top
`default_nettype wire
